// *** common/adc_ctrl_pkg.sv ***
// Package for the converter control block: register map, fields, timing.
// Assumes a 32-bit AHB-Lite slave with one word per byte-offset register.
package adc_ctrl_pkg;

  // ==========================================================
  // Register map (documented byte offsets; bus byte address is offset times reg_index_scale)
  localparam logic [7:0] addr_control_status = 8'h34;
  localparam logic [7:0] addr_result_upper   = 8'h35;
  localparam logic [7:0] addr_result_lower   = 8'h36;
  localparam int         reg_index_scale     = 4;

  // ==========================================================
  // Field positions
  localparam int pos_done          = 7;
  localparam int pos_speed         = 6;
  localparam int pos_converter_on  = 5;
  localparam int pos_calibration   = 4;
  localparam int pos_slow          = 3;
  localparam int pos_amp_select    = 2;
  localparam int channel_width     = 3;
  localparam int result_width      = 10;

  localparam logic [7:0] control_status_reset = 8'h00;
  localparam logic [2:0] channel_last         = 3'h6;

  // ==========================================================
  // Timing
  localparam int clock_mhz          = 50;
  localparam int sample_cycles      = 2;
  localparam int conversion_cycles  = sample_cycles + result_width;
  localparam int stabilization_us   = 10;
  localparam int stabilization_cnt  = stabilization_us * clock_mhz;
  localparam logic [1:0] div_full    = 2'h0;
  localparam logic [1:0] div_half    = 2'h1;
  localparam logic [1:0] div_quarter = 2'h3;

  typedef enum logic [1:0] {
    conv_off,
    conv_settle,
    conv_run
  } conv_state_type;

  typedef struct packed {
    logic       speed;
    logic       converter_on;
    logic [2:0] channel_select;
  } control_type;

  typedef struct packed {
    logic calibration;
    logic slow;
    logic amplifier_select;
  } amp_type;

  typedef struct packed {
    logic       power_on;
    logic       amp_on;
    logic       amp_through;
    logic       amp_zero;
    logic [2:0] channel;
  } analog_ctrl_type;

endpackage

// *** hw/adc_ctrl.sv ***
// Digital control of a 10-bit successive-approximation converter.
// Assumes the analog core returns one comparator bit per converter clock,
// and an AHB-Lite master with single whole-word transfers.
// ==========================================================
// Overview of operation
// - Converter-on set starts continuous channel conversions
// - Each conversion end loads result, sets done
// - Reading upper result clears done flag
// - Clearing converter-on powers down converter and amplifier
// - Wait mode leaves converter untouched
// - Halt disables; stabilization wait after wake-up
// - Control/status resets zero; done bit read-only
// - Three-bit channel select picks inputs 0-6
// - Upper result shows result bits nine to two
// - Lower result shows result bits one, zero
// - Lower result top three bits read zero
// - Calibration bit ties amplifier input to zero
// - Clock select: half, full, or quarter rate
// - Amplifier-select bit routes channel through amplifier
// - Registers at byte addresses 34h, 35h, 36h; here one word each at bus addresses D0h, D4h, D8h
// - Selected amplifier applies fixed gain eight
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module adc_ctrl
  import adc_ctrl_pkg::*;
#(
  parameter int stabilization_cycles = stabilization_cnt
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        halt_mode,
  input  wire logic        wait_mode,
  input  wire logic        comparator,
  output analog_ctrl_type  analog_ctrl,
  output logic             sample_hold,
  output logic [9:0]       trial_code
);

  // ==========================================================
  // Bus address phase capture
  logic       wr_pend_reg;
  logic       rd_pend_reg;
  logic [7:0] addr_reg;
  logic       addr_ok;
  logic       take;

  assign take    = hsel && hready && htrans[1];
  assign addr_ok = (haddr[31:8] == 24'h0) && (haddr[1:0] == 2'h0);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
    end else begin
      wr_pend_reg <= take && hwrite;
      rd_pend_reg <= take && !hwrite;
      if (take) begin
        addr_reg <= haddr[7:0];
      end
    end
  end

  // Registers answer with zero wait states and always OKAY
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // bus byte address of each documented byte offset
  localparam logic [7:0] word_status = 8'(addr_control_status * reg_index_scale);
  localparam logic [7:0] word_upper  = 8'(addr_result_upper * reg_index_scale);
  localparam logic [7:0] word_lower  = 8'(addr_result_lower * reg_index_scale);

  logic hit_status;
  logic hit_upper;
  logic hit_lower;
  assign hit_status = addr_ok && (haddr[7:0] == word_status);
  assign hit_upper  = addr_ok && (haddr[7:0] == word_upper);
  assign hit_lower  = addr_ok && (haddr[7:0] == word_lower);

  // ==========================================================
  // Software registers
  control_type ctrl_reg;
  amp_type     amp_reg;
  logic        done_reg;
  logic [9:0]  result_reg;
  logic        upper_read;
  logic        conv_end;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg.speed          <= control_status_reset[pos_speed];
      ctrl_reg.converter_on   <= control_status_reset[pos_converter_on];
      ctrl_reg.channel_select <= control_status_reset[channel_width-1:0];
      amp_reg  <= amp_type'(3'h0);
    end else if (wr_pend_reg) begin
      if (addr_reg == word_status) begin
        // done bit is not writable; bits four, three ignored
        ctrl_reg.speed          <= hwdata[pos_speed];
        ctrl_reg.converter_on   <= hwdata[pos_converter_on];
        ctrl_reg.channel_select <= hwdata[channel_width-1:0];
      end
      if (addr_reg == word_lower) begin
        amp_reg.calibration      <= hwdata[pos_calibration];
        amp_reg.slow             <= hwdata[pos_slow];
        amp_reg.amplifier_select <= hwdata[pos_amp_select];
      end
    end
  end

  // A read right behind a write or an upper read must see the new state,
  // since read data is taken in the address phase
  control_type ctrl_view;
  amp_type     amp_view;
  logic        done_view;
  always_comb begin
    ctrl_view = ctrl_reg;
    amp_view  = amp_reg;
    done_view = conv_end || (done_reg && !upper_read);
    if (wr_pend_reg && (addr_reg == word_status)) begin
      ctrl_view.speed          = hwdata[pos_speed];
      ctrl_view.converter_on   = hwdata[pos_converter_on];
      ctrl_view.channel_select = hwdata[channel_width-1:0];
    end
    if (wr_pend_reg && (addr_reg == word_lower)) begin
      amp_view.calibration      = hwdata[pos_calibration];
      amp_view.slow             = hwdata[pos_slow];
      amp_view.amplifier_select = hwdata[pos_amp_select];
    end
  end

  // Read data is registered in the address phase so hrdata is a flop
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (hit_status) begin
      rd_byte = {done_view, ctrl_view.speed, ctrl_view.converter_on, 2'h0,
                 ctrl_view.channel_select};
    end else if (hit_upper) begin
      rd_byte = result_reg[9:2];
    end else if (hit_lower) begin
      // top three bits zero, low bits hold result bits one, zero
      rd_byte = {3'h0, amp_view.calibration, amp_view.slow, amp_view.amplifier_select,
                 result_reg[1:0]};
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= {24'h00_0000, rd_byte};
    end
  end

  assign upper_read = rd_pend_reg && (addr_reg == word_upper);

  // ==========================================================
  // converter clock enable from divider
  logic [1:0] div_cnt_reg;
  logic [1:0] div_limit;
  logic       conv_tick;

  always_comb begin
    if (amp_reg.slow) begin
      div_limit = div_quarter;
    end else if (ctrl_reg.speed) begin
      div_limit = div_full;
    end else begin
      div_limit = div_half;
    end
  end

  assign conv_tick = (div_cnt_reg >= div_limit);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      div_cnt_reg <= 2'h0;
    end else if (conv_tick) begin
      div_cnt_reg <= 2'h0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 2'h1;
    end
  end

  // ==========================================================
  // Conversion sequencer
  conv_state_type state_reg;
  logic [31:0]    settle_cnt_reg;
  logic [3:0]     step_reg;
  logic [9:0]     sar_reg;
  logic           enabled;
  logic [3:0]     bit_idx;

  // off when software clears it or during halt
  assign enabled = ctrl_reg.converter_on && !halt_mode;

  // Bit under trial: steps after sampling walk from the top bit down
  assign bit_idx = 4'(result_width - 1 + sample_cycles) - step_reg;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg      <= conv_off;
      settle_cnt_reg <= 32'h0;
      step_reg       <= 4'h0;
      sar_reg        <= 10'h000;
    end else if (!enabled) begin
      state_reg <= conv_off;
    end else begin
      // wait mode is not looked at here
      case (state_reg)
        conv_off: begin
          state_reg      <= conv_settle;
          settle_cnt_reg <= 32'h0;
        end
        conv_settle: begin
          if (settle_cnt_reg >= 32'(stabilization_cycles - 1)) begin
            state_reg <= conv_run;
            step_reg  <= 4'h0;
            sar_reg   <= 10'h000;
          end else begin
            settle_cnt_reg <= settle_cnt_reg + 32'h1;
          end
        end
        conv_run: begin
          // sample, ten trial steps, then restart
          if (conv_tick) begin
            if (step_reg == 4'(conversion_cycles - 1)) begin
              step_reg <= 4'h0;
              sar_reg  <= 10'h000;
            end else begin
              step_reg <= step_reg + 4'h1;
              if (step_reg == 4'(sample_cycles - 1)) begin
                // Top bit is the first trial
                sar_reg[result_width - 1] <= 1'b1;
              end else if (step_reg >= 4'(sample_cycles)) begin
                // Keep the bit if the trial is not above the input, try the next
                sar_reg[bit_idx]        <= comparator;
                sar_reg[bit_idx - 4'h1] <= 1'b1;
              end
            end
          end
        end
        default: state_reg <= conv_off;
      endcase
    end
  end

  assign conv_end = enabled && (state_reg == conv_run) && conv_tick &&
                    (step_reg == 4'(conversion_cycles - 1));

  // result and done flag together; set wins over a clearing read
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      result_reg <= 10'h000;
      done_reg   <= 1'b0;
    end else if (conv_end) begin
      // Lowest bit is decided at the last tick itself
      result_reg <= {sar_reg[result_width-1:1], comparator};
      done_reg   <= 1'b1;
    end else if (upper_read) begin
      done_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Analog core controls
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      analog_ctrl <= analog_ctrl_type'(7'h00);
      sample_hold <= 1'b0;
    end else begin
      // power and amplifier follow the on bit, forced off during halt
      analog_ctrl.power_on    <= enabled;
      analog_ctrl.amp_on      <= enabled;
      analog_ctrl.amp_through <= amp_reg.amplifier_select;
      analog_ctrl.amp_zero    <= amp_reg.calibration;
      // codes above six select input six
      analog_ctrl.channel     <= (ctrl_reg.channel_select > channel_last) ?
                                 channel_last : ctrl_reg.channel_select;
      sample_hold <= enabled && (state_reg == conv_run) &&
                     (step_reg < 4'(sample_cycles));
    end
  end

  // Trial code must not lag the comparator sample, so it is the register itself
  assign trial_code = sar_reg;

endmodule

// *** bench/adc_ctrl_checker.sv ***
// Assertions on the ports of the converter control block.
// Assumes binding to adc_ctrl; zero-wait AHB-Lite slave.
`timescale 1ns/1ps
module adc_ctrl_checker
  import adc_ctrl_pkg::*;
(
  input wire logic            clock,
  input wire logic            rstn,
  input wire logic            hsel,
  input wire logic [31:0]     haddr,
  input wire logic [1:0]      htrans,
  input wire logic            hwrite,
  input wire logic            hready,
  input wire logic [31:0]     hrdata,
  input wire logic            hreadyout,
  input wire logic            hresp,
  input wire logic            halt_mode,
  input wire analog_ctrl_type analog_ctrl,
  input wire logic            sample_hold
);
  // ==========================================================
  // Helpers
  localparam logic [31:0] cs_a = 32'(addr_control_status) * reg_index_scale;
  localparam logic [31:0] up_a = 32'(addr_result_upper) * reg_index_scale;
  localparam logic [31:0] lo_a = 32'(addr_result_lower) * reg_index_scale;
  logic rd;
  assign rd = hsel && hready && htrans[1] && !hwrite;
  sequence read_at(a);
    rd && haddr == a;
  endsequence
  sequence read_unmapped;
    rd && haddr != cs_a && haddr != up_a && haddr != lo_a;
  endsequence
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // Properties
  a_ready_high: assert property (hreadyout)
    else $error("wait state inserted");
  a_resp_okay: assert property (!hresp)
    else $error("error response");
  a_read_pad: assert property (rd |=> hrdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_status_reserved: assert property (read_at(cs_a) |=> hrdata[4:3] == 2'h0)
    else $error("status reserved bits set");
  a_lower_top: assert property (read_at(lo_a) |=> hrdata[7:5] == 3'h0)
    else $error("lower result top bits set");
  a_unmapped_zero: assert property (read_unmapped |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_amp_follows: assert property (!analog_ctrl.power_on |-> !analog_ctrl.amp_on)
    else $error("amplifier on while converter off");
  a_off_quiet: assert property (!analog_ctrl.power_on [*2] |-> !sample_hold)
    else $error("sampling while off");
  a_halt_quiet: assert property (halt_mode [*2] |-> !sample_hold)
    else $error("sampling during halt");
  a_wake_settle: assert property ($fell(halt_mode) |-> !sample_hold [*2])
    else $error("sampling without settle after wake");
  a_channel_range: assert property (analog_ctrl.channel != 3'h7)
    else $error("channel code out of range");
endmodule

bind adc_ctrl adc_ctrl_checker adc_ctrl_checker_i (.clock(clock), .rstn(rstn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .halt_mode(halt_mode), .analog_ctrl(analog_ctrl),
  .sample_hold(sample_hold));

// *** bench/adc_ctrl_bench.sv ***
// Self-checking bench for the converter control block.
// Assumes an ideal input level and a comparator that keeps bits at or below it.
`timescale 1ns/1ps
module adc_ctrl_bench
  import adc_ctrl_pkg::*;
;
  localparam int          stab   = 4;
  localparam logic [31:0] cs_a   = 32'(addr_control_status) * reg_index_scale;
  localparam logic [31:0] up_a   = 32'(addr_result_upper) * reg_index_scale;
  localparam logic [31:0] lo_a   = 32'(addr_result_lower) * reg_index_scale;
  localparam logic [9:0]  target = 10'h2a5;
  logic            clock, rstn, hsel, hwrite, hready, hreadyout, hresp;
  logic            halt_mode, wait_mode, comparator, sample_hold, prev_sh;
  logic [31:0]     haddr, hwdata, hrdata, rd;
  logic [1:0]      htrans;
  logic [2:0]      hsize;
  logic [9:0]      trial_code;
  analog_ctrl_type analog_ctrl;
  int              num_errors = 0;
  int              check_count = 0;
  int              n;

  adc_ctrl #(.stabilization_cycles(stab)) adc_ctrl_i (.clock(clock), .rstn(rstn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .halt_mode(halt_mode), .wait_mode(wait_mode),
    .comparator(comparator), .analog_ctrl(analog_ctrl), .sample_hold(sample_hold),
    .trial_code(trial_code));
  assign hready = hreadyout;
  // Ideal input: a trial code at or below the level is kept
  assign comparator = trial_code <= target;
  always @(posedge clock) prev_sh <= sample_hold;

  // ==========================================================
  // Shared tasks
  task automatic results();
    if (num_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_up();
    check(32'h0, 32'h1);
    results();
  endtask
  task automatic wait_ready();
    int k;
    k = 0;
    @(posedge clock);
    while (hreadyout !== 1'b1) begin
      if (++k > 50) give_up();
      @(posedge clock);
    end
  endtask
  // Single word transfer; read data lands in rd
  task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_ready();
    rd = hrdata;
  endtask
  task automatic wait_done();
    int k;
    k = 0;
    do begin
      bus(1'b0, cs_a, 8'h0);
      if (++k > 300) give_up();
    end while (rd[7] !== 1'b1);
  endtask
  task automatic next_sample(output int c);
    c = 0;
    do begin
      @(posedge clock);
      if (++c > 400) give_up();
    end while (!(sample_hold === 1'b1 && prev_sh === 1'b0));
  endtask

  // ==========================================================
  // Scenarios
  task automatic s_reset();
    bus(1'b0, cs_a, 8'h0);
    check(rd, 32'h0);
    bus(1'b0, lo_a, 8'h0);
    check(rd[7:2], 6'h0);
    bus(1'b1, 32'hdc, 8'hff);
    bus(1'b0, 32'hdc, 8'h0);
    check(rd, 32'h0);
  endtask
  task automatic s_regs();
    bus(1'b1, cs_a, 8'h46);
    bus(1'b0, cs_a, 8'h0);
    check(rd, 32'h46);
    bus(1'b1, lo_a, 8'hff);
    bus(1'b0, lo_a, 8'h0);
    check(rd[7:2], 6'h07);
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, cs_a, 8'(c));
      repeat (2) @(posedge clock);
      check(analog_ctrl.channel, (c > 6) ? 32'(channel_last) : 32'(c));
    end
  endtask
  task automatic s_convert();
    // Slow rate leaves time to read before the next end
    // amplifier only with slowest divider
    bus(1'b1, lo_a, 8'h1c);
    bus(1'b1, cs_a, 8'h63);
    repeat (2) @(posedge clock);
    check({analog_ctrl.power_on, analog_ctrl.amp_on, analog_ctrl.amp_through,
      analog_ctrl.amp_zero}, 32'hf);
    bus(1'b1, lo_a, 8'h08);
    for (int i = 0; i < 2; i++) begin
      // poll, lower byte, then upper byte
      wait_done();
      bus(1'b0, lo_a, 8'h0);
      check(rd[1:0], target[1:0]);
      bus(1'b0, up_a, 8'h0);
      check(rd, 32'(target[9:2]));
      bus(1'b0, cs_a, 8'h0);
      check(rd[7], 1'b0);
    end
    // word read of the upper byte alone
    wait_done();
    bus(1'b0, up_a, 8'h0);
    check(rd, 32'(target[9:2]));
    bus(1'b0, cs_a, 8'h0);
    check(rd[7], 1'b0);
  endtask
  task automatic s_off();
    bus(1'b1, cs_a, 8'h03);
    repeat (2) @(posedge clock);
    check({analog_ctrl.power_on, analog_ctrl.amp_on}, 32'h0);
  endtask
  task automatic s_speed();
    // wait mode held on while converting
    wait_mode <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, lo_a, 8'(m[1]) << 3);
      bus(1'b1, cs_a, 8'h20 | (8'(m[0]) << 6));
      next_sample(n);
      next_sample(n);
      check(n, m[1] ? 48 : (m[0] ? 12 : 24));
    end
  endtask
  task automatic s_halt();
    halt_mode <= 1'b1;
    repeat (20) @(posedge clock);
    check(analog_ctrl.power_on, 1'b0);
    halt_mode <= 1'b0;
    next_sample(n);
    check(n > stab, 1'b1);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    {rstn, hsel, hwrite, halt_mode, wait_mode} = 5'h0;
    {haddr, hwdata, htrans} = 66'h0;
    hsize = 3'h2;
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    s_reset();
    s_regs();
    s_convert();
    s_off();
    s_speed();
    s_halt();
    results();
  end
endmodule
